/* File: rtl/led_connectivity_test.sv */
// led connectivity self-test: production test on the stimulus/result pins,
// field test started and read back over i2c, stepped by the i2c clock
// assumes sense_i comes from per-channel analog pass comparators and
// chip_ok_i from the device's own health check; all pins are asynchronous
//
// How it works
// - stimulus low forces the result pin low regardless of test state
// - stimulus high shows the outcome of the current step on the result pin
// - production test ignores the external reset pin and the io supply pin
// - first high phase after power-on answers 1 if the chip is functional
// - after ack 1 each high phase reports one led connection as 1 or 0
// - the last high phase of the pattern ends the production test
// - writing 01h to register 0Ch starts the field led test when bits 6 and 5 of register 0Bh are set
// - field result is readable at 0Ch in the next i2c transaction
// - field test steps on i2c clock edges; host keeps it at 50 kHz or less
// - result settles within 10 us of a stimulus step
module led_connectivity_test
	import led_test_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = led_test_pkg::I2C_DEV_ADDR
)(
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_b_i,
	input  wire logic                       ext_reset_pin_b_i,
	input  wire logic                       io_supply_pin_ok_i,
	input  wire logic                       test_stimulus_in_i,
	output logic                            test_result_out_o,
	input  wire logic [led_test_pkg::N_CH-1:0] sense_i,
	input  wire logic                       chip_ok_i,
	input  wire logic                       scl_clk_i,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe_o
);
	import led_test_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [4:0] to_ok_field(input logic [N_CH-1:0] s);
		to_ok_field = {s[0], s[1], s[2], s[3], s[4]};
	endfunction

	function automatic logic pick_ch(input logic [N_CH-1:0] s, input logic [2:0] idx);
		pick_ch = s[idx];
	endfunction

	// ==========================================================
	// pin synchronisers (ref domain)
	logic stim_s1, stim_s2, stim_s3;
	logic xrst_s1, xrst_s2;
	logic iook_s1, iook_s2;
	logic cok_s1, cok_s2;
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic [N_CH-1:0] sen_s1, sen_s2;

	always_ff @(posedge ref_clk_i)
	begin
		stim_s1 <= test_stimulus_in_i;
		stim_s2 <= stim_s1;
		stim_s3 <= stim_s2;
		xrst_s1 <= ext_reset_pin_b_i;
		xrst_s2 <= xrst_s1;
		iook_s1 <= io_supply_pin_ok_i;
		iook_s2 <= iook_s1;
		cok_s1  <= chip_ok_i;
		cok_s2  <= cok_s1;
		scl_s1  <= scl_clk_i;
		scl_s2  <= scl_s1;
		scl_s3  <= scl_s2;
		sda_s1  <= sda_i;
		sda_s2  <= sda_s1;
		sda_s3  <= sda_s2;
		sen_s1  <= sense_i;
		sen_s2  <= sen_s1;
	end

	wire stim_rise = stim_s2 & ~stim_s3;
	wire stim_fall = ~stim_s2 & stim_s3;

	// ==========================================================
	// production test, reset by power-on only
	pt_state_t pt_state_r, pt_state_nxt;
	logic [2:0] step_r, step_nxt;
	logic       ack_ok_r;

	// the ext reset pin and io supply are deliberately absent here
	always_comb
	begin
		pt_state_nxt = pt_state_r;
		step_nxt     = step_r;
		unique case (pt_state_r)
			PT_IDLE: if (stim_rise) pt_state_nxt = PT_ACK;
			PT_ACK:
				if (stim_fall)
				begin
					pt_state_nxt = ack_ok_r ? PT_STEP : PT_DONE;
					step_nxt     = 3'h0;
				end
			PT_STEP:
				if (stim_fall)
				begin
					if (step_r == LAST_STEP)
						pt_state_nxt = PT_DONE;
					else
						step_nxt = step_r + 3'h1;
				end
			PT_DONE: pt_state_nxt = PT_DONE;
			default: pt_state_nxt = PT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			pt_state_r <= PT_IDLE;
			step_r     <= 3'h0;
			ack_ok_r   <= 1'b0;
		end
		else
		begin
			pt_state_r <= pt_state_nxt;
			step_r     <= step_nxt;
			if (pt_state_r == PT_ACK && stim_s2)
				ack_ok_r <= cok_s2;
		end
	end

	// outcome of the step now in progress
	wire step_res = (pt_state_r == PT_ACK)  ? cok_s2 :
	                (pt_state_r == PT_STEP) ? pick_ch(sen_s2, step_r) : 1'b0;

	// three ref cycles from pin to pin, four for the ack answer, far inside the settling limit
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			test_result_out_o <= 1'b0;
		else
			test_result_out_o <= stim_s2 & step_res;
	end

	// ==========================================================
	// i2c slave on the sampled bus, reset by power-on or the ext reset pin
	wire i2_rst    = ~rst_b_i | ~xrst_s2;
	wire scl_rise  = scl_s2 & ~scl_s3;
	wire scl_fall  = ~scl_s2 & scl_s3;
	wire bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	wire bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

	i2c_state_t i2_state_r;
	logic [7:0] sh_r;
	logic [3:0] cnt_r;
	logic       rw_r;
	logic [7:0] ptr_r;
	logic [7:0] enables_r;
	test_ctrl_t ctrl_r;
	logic       go_tgl_r;
	logic       oe_r;

	wire        byte_done = scl_fall & (cnt_r == BYTE_BITS);
	wire        addr_hit  = (sh_r[7:1] == DEV_ADDR);
	wire        fld_ready = enables_r[NSTBY_BIT] & enables_r[EN_BOOST_BIT];
	wire [7:0]  rdata     = (ptr_r == REG_TEST_CTRL) ? ctrl_r :
	                        (ptr_r == REG_ENABLES)   ? enables_r : 8'h00;
	wire        wr_strobe = (i2_state_r == I2_WDAT) & byte_done;
	wire        start_req = wr_strobe & (ptr_r == REG_TEST_CTRL) & sh_r[EN_TEST_BIT]
	                        & fld_ready;

	// field result returning from the scl domain
	logic done_s1, done_s2, done_s3;
	logic [N_CH-1:0] ft_res_r;
	logic            done_tgl_r;

	always_ff @(posedge ref_clk_i)
	begin
		done_s1 <= done_tgl_r;
		done_s2 <= done_s1;
		done_s3 <= done_s2;
	end

	wire ft_done = done_s2 ^ done_s3;

	always_ff @(posedge ref_clk_i)
	begin
		if (i2_rst)
		begin
			i2_state_r <= I2_IDLE;
			sh_r       <= 8'h00;
			cnt_r      <= 4'h0;
			rw_r       <= 1'b0;
			ptr_r      <= 8'h00;
			oe_r       <= 1'b0;
			enables_r  <= ENABLES_RST;
			ctrl_r     <= TEST_CTRL_RST;
			go_tgl_r   <= 1'b0;
		end
		else
		begin
			// the scl-side word is frozen while the done toggle travels
			if (ft_done)
			begin
				ctrl_r.ok      <= to_ok_field(ft_res_r);
				ctrl_r.en_test <= 1'b0;
			end
			if (start_req)
			begin
				go_tgl_r       <= ~go_tgl_r;
				ctrl_r.en_test <= 1'b1;
			end
			if (wr_strobe && ptr_r == REG_ENABLES)
				enables_r <= sh_r;
			if (scl_rise && (i2_state_r == I2_ADDR || i2_state_r == I2_PTR
			                 || i2_state_r == I2_WDAT))
			begin
				sh_r  <= {sh_r[6:0], sda_s2};
				cnt_r <= cnt_r + 4'h1;
			end
			if (bus_stop)
			begin
				i2_state_r <= I2_IDLE;
				oe_r       <= 1'b0;
			end
			else if (bus_start)
			begin
				i2_state_r <= I2_ADDR;
				cnt_r      <= 4'h0;
				oe_r       <= 1'b0;
			end
			else
			begin
				unique case (i2_state_r)
					I2_IDLE: i2_state_r <= I2_IDLE;
					I2_ADDR:
						if (byte_done)
						begin
							cnt_r      <= 4'h0;
							rw_r       <= sh_r[0];
							oe_r       <= addr_hit & iook_s2;
							i2_state_r <= addr_hit ? I2_AACK : I2_IDLE;
						end
					I2_AACK, I2_RACK:
						if (scl_fall)
						begin
							if (rw_r)
							begin
								// read data at the pointer, result of the last
								sh_r       <= rdata;
								oe_r       <= ~rdata[7];
								cnt_r      <= 4'h1;
								i2_state_r <= I2_RDAT;
							end
							else
							begin
								oe_r       <= 1'b0;
								i2_state_r <= I2_PTR;
							end
						end
						else if (scl_rise && i2_state_r == I2_RACK && sda_s2)
							i2_state_r <= I2_IDLE;
					I2_PTR, I2_WDAT:
						if (byte_done)
						begin
							if (i2_state_r == I2_PTR)
								ptr_r <= sh_r;
							cnt_r      <= 4'h0;
							oe_r       <= 1'b1;
							i2_state_r <= (i2_state_r == I2_PTR) ? I2_PACK : I2_WACK;
						end
					I2_PACK, I2_WACK:
						if (scl_fall)
						begin
							oe_r       <= 1'b0;
							i2_state_r <= I2_WDAT;
						end
					I2_RDAT:
						if (byte_done)
						begin
							oe_r       <= 1'b0;
							cnt_r      <= 4'h0;
							i2_state_r <= I2_RACK;
						end
						else if (scl_fall)
						begin
							oe_r  <= ~sh_r[6];
							sh_r  <= {sh_r[6:0], 1'b0};
							cnt_r <= cnt_r + 4'h1;
						end
					default: i2_state_r <= I2_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else
		begin
			sda_o    <= 1'b0;
			sda_oe_o <= oe_r;
		end
	end

	// ==========================================================
	// field test sequencer on the i2c clock; it only runs while scl toggles,
	// which is why the host must keep clocking until the result is read
	logic srst_s1, srst_s2;
	logic go_s1, go_s2, go_s3;
	logic [N_CH-1:0] fsen_s1, fsen_s2;
	logic       ft_busy_r;
	logic [2:0] ft_step_r;

	always_ff @(posedge scl_clk_i)
	begin
		srst_s1 <= rst_b_i;
		srst_s2 <= srst_s1;
		go_s1   <= go_tgl_r;
		go_s2   <= go_s1;
		go_s3   <= go_s2;
		fsen_s1 <= sense_i;
		fsen_s2 <= fsen_s1;
	end

	always_ff @(posedge scl_clk_i)
	begin
		if (!srst_s2)
		begin
			ft_busy_r  <= 1'b0;
			ft_step_r  <= 3'h0;
			ft_res_r   <= '0;
			done_tgl_r <= 1'b0;
		end
		else if (go_s2 ^ go_s3)
		begin
			ft_busy_r <= 1'b1;
			ft_step_r <= 3'h0;
			ft_res_r  <= '0;
		end
		else if (ft_busy_r)
		begin
			ft_res_r[ft_step_r] <= fsen_s2[ft_step_r];
			if (ft_step_r == LAST_STEP)
			begin
				ft_busy_r  <= 1'b0;
				done_tgl_r <= ~done_tgl_r;
			end
			else
				ft_step_r <= ft_step_r + 3'h1;
		end
	end

	// ==========================================================
	// checks
	localparam int SETTLE_MAX = SETTLE_CYC;

	sequence s_stim_high_in_ack;
		pt_state_r == PT_ACK && stim_s2;
	endsequence

	property p_low_when_stim_low;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		!stim_s2 |=> !test_result_out_o;
	endproperty
	a_low_when_stim_low: assert property (p_low_when_stim_low)
		else $error("result high while stimulus low");

	property p_shows_step;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		stim_s2 |=> test_result_out_o == $past(step_res);
	endproperty
	a_shows_step: assert property (p_shows_step)
		else $error("result does not show current step");

	property p_ack_answer;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		s_stim_high_in_ack ##1 s_stim_high_in_ack |-> test_result_out_o == $past(cok_s2);
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("ack does not follow chip health");

	property p_ext_reset_ignored;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!xrst_s2 && pt_state_r == PT_STEP && !stim_fall) |=> pt_state_r == PT_STEP;
	endproperty
	a_ext_reset_ignored: assert property (p_ext_reset_ignored)
		else $error("production test disturbed by ext reset");

	property p_step_advance;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(pt_state_r == PT_STEP && stim_fall && step_r != LAST_STEP)
			|=> step_r == $past(step_r) + 3'h1 && pt_state_r == PT_STEP;
	endproperty
	a_step_advance: assert property (p_step_advance)
		else $error("step counter did not advance");

	property p_last_disengages;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(pt_state_r == PT_STEP && stim_fall && step_r == LAST_STEP)
			|=> pt_state_r == PT_DONE ##1 !test_result_out_o;
	endproperty
	a_last_disengages: assert property (p_last_disengages)
		else $error("test not ended after last pattern phase");

	property p_settle;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(stim_s1) ##1 stim_s2[*3] |-> ##[0:SETTLE_MAX] test_result_out_o == step_res;
	endproperty
	a_settle: assert property (p_settle)
		else $error("result not settled in time");

	property p_start_toggle;
		@(posedge ref_clk_i) disable iff (i2_rst)
		start_req |=> go_tgl_r != $past(go_tgl_r) && ctrl_r.en_test;
	endproperty
	a_start_toggle: assert property (p_start_toggle)
		else $error("test start write not taken");

	property p_result_capture;
		@(posedge ref_clk_i) disable iff (i2_rst)
		(ft_done && !start_req) |=> ctrl_r.ok == to_ok_field($past(ft_res_r)) && !ctrl_r.en_test;
	endproperty
	a_result_capture: assert property (p_result_capture)
		else $error("field result not captured");

	property p_ft_steps;
		@(posedge scl_clk_i) disable iff (!srst_s2)
		(ft_busy_r && !(go_s2 ^ go_s3) && ft_step_r != LAST_STEP)
			|=> ft_step_r == $past(ft_step_r) + 3'h1;
	endproperty
	a_ft_steps: assert property (p_ft_steps)
		else $error("field step not advanced on scl edge");

endmodule

/* File: rtl/led_test_pkg.sv */
// constants, types and state codes for the led connectivity test block
// assumes a 10 MHz reference clock; the i2c serial clock is a separate domain
package led_test_pkg;

	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned SETTLE_US      = 10;
	// longest time, so rounded down
	localparam int unsigned SETTLE_CYC     = (SETTLE_US * CLK_HZ) / 1_000_000;
	localparam int unsigned FT_SCL_MAX_KHZ = 50;

	// ==========================================================
	// i2c addressing and register map
	localparam logic [6:0] I2C_DEV_ADDR   = 7'h4C;
	localparam logic [7:0] REG_ENABLES    = 8'h0B;
	localparam logic [7:0] REG_TEST_CTRL  = 8'h0C;
	localparam logic [7:0] ENABLES_RST    = 8'h08;
	localparam logic [7:0] TEST_CTRL_RST  = 8'h00;
	localparam int unsigned NSTBY_BIT     = 6;
	localparam int unsigned EN_BOOST_BIT  = 5;
	localparam int unsigned EN_TEST_BIT   = 0;
	localparam logic [3:0] BYTE_BITS      = 4'h8;

	// ==========================================================
	// channels: index 0..3 are led1..led4, index 4 is the flash led
	localparam int unsigned N_CH      = 5;
	localparam logic [2:0]  LAST_STEP = 3'h4;

	// led test control layout: led1_ok at bit 6 down to flashled_ok at bit 2
	typedef struct packed {
		logic       rsv7;
		logic [4:0] ok;
		logic       rsv1;
		logic       en_test;
	} test_ctrl_t;

	// ==========================================================
	// state codes
	typedef enum logic [3:0] {
		PT_IDLE = 4'b0001,
		PT_ACK  = 4'b0010,
		PT_STEP = 4'b0100,
		PT_DONE = 4'b1000
	} pt_state_t;

	typedef enum logic [8:0] {
		I2_IDLE = 9'b0_0000_0001,
		I2_ADDR = 9'b0_0000_0010,
		I2_AACK = 9'b0_0000_0100,
		I2_PTR  = 9'b0_0000_1000,
		I2_PACK = 9'b0_0001_0000,
		I2_WDAT = 9'b0_0010_0000,
		I2_WACK = 9'b0_0100_0000,
		I2_RDAT = 9'b0_1000_0000,
		I2_RACK = 9'b1_0000_0000
	} i2c_state_t;

endpackage

/* File: tb/i2c_host_model.sv */
// i2c host model: makes the serial clock and pulls the data line low
// assumes the bench resolves the wire with a pull-up from every enable
module i2c_host_model (
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// ====
	// bus timing
	// quarter bit of 5 us gives 50 kHz, the field test limit
	localparam int Q = 5000;

	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// fast pulses with data high, only to clear the serial-clock reset synchroniser
	task automatic pulses(input int n);
		repeat (n)
		begin
			#15 scl_o = 1'b0;
			#15 scl_o = 1'b1;
		end
	endtask

	task automatic bit_clk(output logic smp);
		#Q scl_o = 1'b1;
		#Q smp = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask

	// data is released while the clock is low and pulled low while it is high; works as repeated start too
	task automatic start();
		sda_low_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask

	task automatic stop();
		sda_low_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b0;
		#Q;
	endtask

	// msb first; host_ack high pulls the ninth bit low
	task automatic xfer(input logic [7:0] wr, input logic host_ack,
		output logic [7:0] rd, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_low_o = ~wr[i];
			bit_clk(rd[i]);
		end
		sda_low_o = host_ack;
		bit_clk(ack);
		sda_low_o = 1'b0;
	endtask
endmodule

/* File: tb/tb_led_connectivity_test.sv */
// bench for the led connectivity test: production pins, then field test over i2c
// assumes the host model for the serial bus and a pull-up on the data wire
module tb_led_connectivity_test;
	timeunit 1ns;
	timeprecision 1ns;
	import led_test_pkg::*;

	localparam int LIMIT = 70000;

	logic            ref_clk_i = 1'b0;
	logic            rst_b_i = 1'b0;
	logic            ext_b = 1'b0;
	logic            io_ok = 1'b0;
	logic            stim = 1'b0;
	logic [N_CH-1:0] sense = 5'h0D;
	logic            chip_ok = 1'b1;
	logic            result;
	logic            scl;
	logic            host_low;
	logic            sda_o;
	logic            sda_oe;
	wire logic       sda_w = ~(host_low | (sda_oe & ~sda_o));
	int              failures = 0;
	int              checked = 0;
	int              cycles = 0;

	led_connectivity_test i_dut (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ext_reset_pin_b_i(ext_b),
		.io_supply_pin_ok_i(io_ok), .test_stimulus_in_i(stim),
		.test_result_out_o(result), .sense_i(sense), .chip_ok_i(chip_ok),
		.scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe));

	i2c_host_model i_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));

	initial
	begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// ====
	// verdict and hang guard
	task automatic complete_run();
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge ref_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			failures++;
			$display("unexpected at %0t: run did not finish", $time);
			complete_run();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// ====
	// production pins: hold each level ten cycles, well under the settle limit
	task automatic phase(input logic lvl, input logic [7:0] exp);
		@(posedge ref_clk_i);
		stim <= lvl;
		repeat (10) @(posedge ref_clk_i);
		#1;
		check({7'h00, result}, exp);
	endtask

	// ====
	// register access over the serial bus
	task automatic send(input logic [7:0] b);
		logic [7:0] r;
		logic       k;
		i_host.xfer(b, 1'b0, r, k);
		check({7'h00, k}, 8'h00);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		i_host.start();
		send({I2C_DEV_ADDR, 1'b0});
		send(a);
		send(d);
		i_host.stop();
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		logic       k;
		i_host.start();
		send({I2C_DEV_ADDR, 1'b0});
		send(a);
		i_host.start();
		send({I2C_DEV_ADDR, 1'b1});
		i_host.xfer(8'hFF, 1'b0, r, k);
		i_host.stop();
		check(r, exp);
	endtask

	// ====
	// main sequence
	initial
	begin
		i_host.pulses(4);
		repeat (20) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		// reset pin and io supply held off: production test must not care
		phase(1'b1, 8'h01);
		phase(1'b0, 8'h00);
		for (int k = 0; k < N_CH; k++)
		begin
			phase(1'b1, {7'h00, sense[k]});
			phase(1'b0, 8'h00);
		end
		phase(1'b1, 8'h00);
		phase(1'b0, 8'h00);
		@(posedge ref_clk_i);
		ext_b <= 1'b1;
		io_ok <= 1'b1;
		sense <= 5'h16;
		repeat (5) @(posedge ref_clk_i);
		rd_reg(REG_TEST_CTRL, TEST_CTRL_RST);
		// start while standby and converter are still off must be refused
		wr_reg(REG_TEST_CTRL, 8'h01);
		rd_reg(REG_TEST_CTRL, TEST_CTRL_RST);
		wr_reg(REG_ENABLES, 8'h60);
		rd_reg(REG_ENABLES, 8'h60);
		wr_reg(REG_TEST_CTRL, 8'h01);
		rd_reg(REG_TEST_CTRL, {1'b0, sense[0], sense[1], sense[2], sense[3], sense[4], 2'b00});
		rd_reg(8'h20, 8'h00);
		// second power-on with a failing health check: ack 0 ends the test
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		chip_ok <= 1'b0;
		sense   <= 5'h1F;
		repeat (3) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		phase(1'b1, 8'h00);
		phase(1'b0, 8'h00);
		@(posedge ref_clk_i);
		chip_ok <= 1'b1;
		phase(1'b1, 8'h00);
		phase(1'b0, 8'h00);
		complete_run();
	end
endmodule
